// ---- core/buck_code_regs.sv ----
// Voltage code register bank for converters four, five and six.
// Assumes a byte register port fed by the two-wire bus engine,
// one request per cycle, and sleep levels already resolved per converter.
`timescale 1ns/1ps

module buck_code_regs
#(
    parameter int STEP_CNT = buck_code_pkg::STEP_CYCLES
)
(
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_srst,
    // Register port
    input  wire buck_code_pkg::reg_req_s    i_req,
    output      buck_code_pkg::reg_rsp_s    o_rsp,
    // Sleep levels for converters four and five
    input  wire logic [1:0]                 i_sleep_mode,
    // Regulator drives: 0 four, 1 five, 2 six
    output      buck_code_pkg::conv_drive_s o_drive [3]
);
    import buck_code_pkg::*;

    localparam logic [7:0] OFS_NORMAL [NUM_CONV] =
        '{OFS_CONV_FOUR_NORMAL, OFS_CONV_FIVE_NORMAL, OFS_CONV_SIX_NORMAL};
    localparam logic [7:0] OFS_SLEEP [NUM_SLEEP] =
        '{OFS_CONV_FOUR_SLEEP, OFS_CONV_FIVE_SLEEP};

    logic [7:0] normal_q [NUM_CONV];
    logic [7:0] sleep_q  [NUM_SLEEP];
    vcode_t     target   [NUM_CONV];
    logic [NUM_CONV-1:0]  hit_normal;
    logic [NUM_SLEEP-1:0] hit_sleep;
    logic [7:0] rd_normal [NUM_CONV];
    logic [7:0] rd_sleep  [NUM_SLEEP];
    reg_rsp_s   rsp_q;

    // ---------------------------------------------------------------
    // Normal-mode code registers and ramps
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CONV; g++)
        begin : g_conv
            assign hit_normal[g] = (i_req.addr == OFS_NORMAL[g]);
            assign rd_normal[g]  = hit_normal[g] ? normal_q[g] : 8'h00;

            // Whole byte: seven-bit code plus ramp-down select
            always_ff @(posedge i_clk_sys)
            begin
                if (i_srst)
                    normal_q[g] <= RST_NORMAL;
                else if (i_req.wr && hit_normal[g])
                    normal_q[g] <= i_req.wdata;
            end

            conv_ramp #(
                .STEP_CNT        (STEP_CNT)
            ) u_ramp (
                .i_clk_sys       (i_clk_sys),
                .i_srst          (i_srst),
                .i_target        (target[g]),
                .i_passive_decay (normal_q[g][RAMP_SEL_BIT]),
                .o_drive         (o_drive[g])
            );

            a_normal_store: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                (i_req.wr && hit_normal[g]) |=> (normal_q[g] == $past(i_req.wdata)))
                else $error("normal code write not stored");

            a_normal_read: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                (i_req.rd && hit_normal[g]) |=> (o_rsp.data == $past(normal_q[g])))
                else $error("normal code read back wrong");
            a_normal_keep: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                !(i_req.wr && hit_normal[g]) |=> $stable(normal_q[g]))
                else $error("normal code moved without a write");
            // Runs through reset on purpose, so a flop that ignores it shows
            a_normal_reset: assert property (@(posedge i_clk_sys)
                disable iff (1'b0)
                i_srst |=> (normal_q[g] == RST_NORMAL
                            && o_drive[g].code == RST_NORMAL[CODE_MSB:CODE_LSB]))
                else $error("normal code not cleared by reset");
            a_pull_select: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                o_drive[g].pull_down |-> !normal_q[g][RAMP_SEL_BIT])
                else $error("pull-down driven with passive decay selected");
            a_decay_direct: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                (normal_q[g][RAMP_SEL_BIT] && target[g] < o_drive[g].code)
                |=> (o_drive[g].code == $past(target[g])))
                else $error("passive decay did not drop the reference at once");
        end
    endgenerate

    // ---------------------------------------------------------------
    // Sleep-mode code registers
    // ---------------------------------------------------------------
    generate
        for (g = 0; g < NUM_SLEEP; g++)
        begin : g_sleep
            assign hit_sleep[g] = (i_req.addr == OFS_SLEEP[g]);
            assign rd_sleep[g]  = hit_sleep[g] ? sleep_q[g] : 8'h00;
            assign target[g]    = i_sleep_mode[g] ? sleep_q[g][CODE_MSB:CODE_LSB]
                                                  : normal_q[g][CODE_MSB:CODE_LSB];

            // Reserved bit never stored, so it cannot read back as one
            always_ff @(posedge i_clk_sys)
            begin
                if (i_srst)
                    sleep_q[g] <= RST_SLEEP;
                else if (i_req.wr && hit_sleep[g])
                    sleep_q[g] <= i_req.wdata & SLEEP_WR_MASK;
            end

            a_sleep_store: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                (i_req.wr && hit_sleep[g])
                |=> (sleep_q[g][CODE_MSB:CODE_LSB] == $past(i_req.wdata[CODE_MSB:CODE_LSB])))
                else $error("sleep code write not stored");

            a_sleep_read: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                (i_req.rd && hit_sleep[g]) |=> (o_rsp.data == ($past(sleep_q[g]) & SLEEP_WR_MASK)))
                else $error("sleep code read back wrong");
            a_sleep_keep: assert property (@(posedge i_clk_sys)
                disable iff (i_srst)
                !(i_req.wr && hit_sleep[g]) |=> $stable(sleep_q[g]))
                else $error("sleep code moved without a write");
            a_sleep_reset: assert property (@(posedge i_clk_sys)
                disable iff (1'b0)
                i_srst |=> (sleep_q[g] == RST_SLEEP))
                else $error("sleep code not cleared by reset");
        end
    endgenerate

    // Converter six has no sleep register in this bank
    assign target[2] = normal_q[2][CODE_MSB:CODE_LSB];

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    // Unmapped offsets still answer, with zero, so the bus engine never waits
    // A read and a write of one offset in one cycle return the old byte
    wire logic       hit_any = (|hit_normal) || (|hit_sleep);
    wire logic [7:0] rd_mux  = rd_normal[0] | rd_normal[1] | rd_normal[2]
                             | rd_sleep[0] | rd_sleep[1];
    wire logic [7:0] rd_data = hit_any ? rd_mux : UNMAPPED_DATA;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
            rsp_q <= '0;
        else
        begin
            rsp_q.valid <= i_req.rd;
            rsp_q.data  <= i_req.rd ? rd_data : rsp_q.data;
        end
    end

    assign o_rsp = rsp_q;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    a_sleep_rsvd: assert property (
        (i_req.rd && |hit_sleep) |=> (o_rsp.valid && !o_rsp.data[RSVD_BIT]))
        else $error("sleep reserved bit read as one");
    a_read_four: assert property (
        (i_req.rd && !i_req.wr && hit_normal[0]) |=> (o_rsp.data == normal_q[0]))
        else $error("converter four normal code read wrong");
    a_unmapped_zero: assert property (
        (i_req.rd && !hit_any) |=> (o_rsp.valid && o_rsp.data == UNMAPPED_DATA))
        else $error("unmapped read not zero");
    a_read_valid: assert property (
        i_req.rd |=> o_rsp.valid)
        else $error("read answered without valid");
    a_rsp_pulse: assert property (
        !i_req.rd |=> !o_rsp.valid)
        else $error("read valid without a read");
    a_rsp_hold: assert property (
        !i_req.rd |=> $stable(o_rsp.data))
        else $error("read data moved without a read");
    a_rsp_reset: assert property (
        disable iff (1'b0)
        i_srst |=> !o_rsp.valid)
        else $error("read valid not cleared by reset");

    // ---------------------------------------------------------------
    // Assertions: sleep code selection
    // ---------------------------------------------------------------
    // Entering sleep with a higher sleep code must start a rise at once
    a_sleep_target: assert property (
        ($rose(i_sleep_mode[0]) && sleep_q[0][CODE_MSB:CODE_LSB] > o_drive[0].code)
        |-> (o_drive[0].ramping && !o_drive[0].pull_down))
        else $error("converter four ignored its sleep code");
    a_sleep_five: assert property (
        ($rose(i_sleep_mode[1]) && sleep_q[1][CODE_MSB:CODE_LSB] > o_drive[1].code)
        |-> (o_drive[1].ramping && !o_drive[1].pull_down))
        else $error("converter five ignored its sleep code");
    a_six_no_sleep: assert property (
        ($changed(i_sleep_mode) && !o_drive[2].ramping && !(i_req.wr && hit_normal[2]))
        |=> !o_drive[2].ramping)
        else $error("converter six followed a sleep level");

    c_write_six:  cover property (i_req.wr && hit_normal[2]);
    c_sleep_rd:   cover property (i_req.rd && hit_sleep[1]);
    c_sleep_mode: cover property (i_sleep_mode[1] ##1 o_drive[1].ramping);

endmodule : buck_code_regs

// ---- core/buck_code_pkg.sv ----
// Package for the step-down converter voltage code register bank.
// Assumes one 100 MHz system clock.
// Assumes a byte-wide register port from the chip's two-wire bus engine.
package buck_code_pkg;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CONV_FOUR_NORMAL = 8'h94;
    localparam logic [7:0] OFS_CONV_FOUR_SLEEP  = 8'h95;
    localparam logic [7:0] OFS_CONV_FIVE_NORMAL = 8'h96;
    localparam logic [7:0] OFS_CONV_FIVE_SLEEP  = 8'h97;
    localparam logic [7:0] OFS_CONV_SIX_NORMAL  = 8'h98;

    // ---------------------------------------------------------------
    // Field layout and reset values
    // ---------------------------------------------------------------
    localparam int          CODE_MSB       = 7;
    localparam int          CODE_LSB       = 1;
    localparam int          RAMP_SEL_BIT   = 0;
    localparam int          RSVD_BIT       = 0;
    localparam logic [7:0]  RST_NORMAL     = 8'h00;
    localparam logic [7:0]  RST_SLEEP      = 8'h00;
    localparam logic [7:0]  SLEEP_WR_MASK  = 8'hFE;
    localparam logic [7:0]  UNMAPPED_DATA  = 8'h00;
    localparam int          NUM_CONV       = 3;
    localparam int          NUM_SLEEP      = 2;

    // ---------------------------------------------------------------
    // Timing: one code step per STEP_TIME_NS while slewing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int STEP_TIME_NS  = 1000;
    localparam int STEP_CYCLES   = (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef logic [6:0] vcode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_s;

    typedef struct packed {
        vcode_t code;
        logic   pull_down;
        logic   ramping;
    } conv_drive_s;

endpackage : buck_code_pkg

// ---- core/conv_ramp.sv ----
// Reference-code ramp for one step-down converter.
// Assumes the target code changes only on register writes or sleep-level changes.
`timescale 1ns/1ps
module conv_ramp
#(
    parameter int STEP_CNT = buck_code_pkg::STEP_CYCLES
)
(
    // Clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_srst,
    // Target and ramp-down mode
    input  wire buck_code_pkg::vcode_t     i_target,
    input  wire logic                      i_passive_decay,
    // Drive to the regulator
    output      buck_code_pkg::conv_drive_s o_drive
);
    import buck_code_pkg::*;

    localparam int CW = $clog2(STEP_CNT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(STEP_CNT - 1);

    vcode_t        code_q;
    vcode_t        code_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    wire logic at_target  = (code_q == i_target);
    wire logic going_down = (i_target < code_q);
    wire logic jump_down  = going_down && i_passive_decay;
    wire logic step_due   = !at_target && !jump_down && (cnt_q == CNT_LAST);

    // ---------------------------------------------------------------
    // Next code
    // ---------------------------------------------------------------
    // Passive decay: reference drops at once, the output bleeds down alone
    assign code_d = jump_down ? i_target
                  : !step_due ? code_q
                  : going_down ? code_q - 7'h01
                  : code_q + 7'h01;
    assign cnt_d  = (at_target || jump_down || step_due) ? '0 : cnt_q + CW'(1);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            code_q <= RST_NORMAL[CODE_MSB:CODE_LSB];
            cnt_q  <= '0;
        end
        else
        begin
            code_q <= code_d;
            cnt_q  <= cnt_d;
        end
    end

    assign o_drive.code      = code_q;
    assign o_drive.pull_down = going_down && !i_passive_decay;
    assign o_drive.ramping   = !at_target;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    a_decay_jump: assert property (
        jump_down |=> (code_q == $past(i_target)))
        else $error("passive decay did not jump to target");
    a_slew_step: assert property (
        (going_down && !i_passive_decay && cnt_q == CNT_LAST && $stable(i_target))
        |=> (code_q == $past(code_q) - 7'h01))
        else $error("active slew did not step down by one");
    a_slew_pulldown: assert property (
        (going_down && !i_passive_decay) |-> o_drive.pull_down)
        else $error("active pull-down missing while slewing down");
    a_no_early_step: assert property (
        (!at_target && !jump_down && cnt_q != CNT_LAST) |=> $stable(code_q) || $changed(i_target))
        else $error("code stepped before its slot");

    c_slew_down: cover property (going_down && !i_passive_decay ##1 step_due);
    c_decay:     cover property (jump_down);

endmodule : conv_ramp

// ---- dv/host_model.sv ----
// Host model: drives the byte register port as the bus engine would.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module host_model
(
    // Clock and response
    input  wire logic                    i_clk_sys,
    input  wire buck_code_pkg::reg_rsp_s i_rsp,
    // Request
    output      buck_code_pkg::reg_req_s o_req
);
    import buck_code_pkg::*;

    initial o_req = '0;

    // Released lines show the inverse, so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_req = '{1'b1, 1'b0, a, d};
        @(posedge i_clk_sys);
        #1;
        o_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_req = '{1'b0, 1'b1, a, ~o_req.wdata};
        @(posedge i_clk_sys);
        #1;
        v = i_rsp.valid;
        d = i_rsp.data;
        o_req = '{1'b0, 1'b0, ~a, o_req.wdata};
    endtask : rd
endmodule : host_model

// ---- dv/tb_buck_code_regs.sv ----
// Bench for the voltage code register bank with a reference model.
// Assumes a step count of 3 so that ramps stay short.
`timescale 1ns/1ps
module tb_buck_code_regs;
    import buck_code_pkg::*;
    localparam int SC = 3;
    logic        i_clk_sys    = 1'b0;
    logic        i_srst       = 1'b1;
    logic [1:0]  i_sleep_mode = 2'b00;
    reg_req_s    req;
    reg_rsp_s    rsp;
    conv_drive_s drv [3];
    int          n_mismatch   = 0;
    int          total_checks = 0;
    int          cyc          = 0;
    int          t;
    int          s;
    int          mem [6];
    logic [7:0]  ofs [6]      = '{8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99};

    host_model host (.i_clk_sys(i_clk_sys), .i_rsp(rsp), .o_req(req));
    buck_code_regs #(.STEP_CNT(SC)) uut (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_req(req), .o_rsp(rsp), .i_sleep_mode(i_sleep_mode), .o_drive(drv));

    initial forever #5 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdx(input int i);
        logic       v;
        logic [7:0] d;
        logic [7:0] e;
        e = (i == 1 || i == 3) ? 8'(mem[i]) & 8'hFE : 8'(mem[i]);
        if (i == 5)
            e = UNMAPPED_DATA;
        host.rd(ofs[i], v, d);
        chk({7'h00, v}, 8'h01);
        chk(d, e);
    endtask : rdx

    task automatic rst_all;
        @(posedge i_clk_sys);
        #1;
        i_srst = 1'b1;
        i_sleep_mode = 2'b00;
        mem = '{default: 0};
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_srst = 1'b0;
    endtask : rst_all

    // Target change by normal write or sleep toggle, then time the arrival
    task automatic go(input int k, input int tgt, input bit slp);
        int st;
        int n;
        int ex;
        bit sel;
        st = drv[k].code;
        n = 0;
        sel = mem[2*k][0];
        if (slp)
        begin
            @(posedge i_clk_sys);
            #1;
            i_sleep_mode[k] = ~i_sleep_mode[k];
            #1;
        end
        else
            host.wr(ofs[2*k], 8'(mem[2*k]));
        chk({7'h00, drv[k].pull_down}, {7'h00, tgt < st && !sel});
        chk({7'h00, drv[k].ramping}, {7'h00, tgt != st});
        ex = (tgt < st && sel) ? 1 : (tgt > st ? tgt - st : st - tgt) * SC;
        while (drv[k].code !== 7'(tgt) && n < 600)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        chk({7'h00, n >= ex - 1 && n <= ex + 1}, 8'h01);
        chk({6'h00, drv[k].ramping, drv[k].pull_down}, 8'h00);
    endtask : go

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h9761));
        for (int p = 0; p < 2; p++)
        begin
            rst_all();
            for (int i = 0; i < 6; i++)
                rdx(i);
            for (int k = 0; k < 3; k++)
                chk({1'b0, drv[k].code}, 8'h00);
            $display("test reset done");
            for (int r = 0; r < 3 && p == 0; r++)
            begin
                for (int i = 0; i < 5; i++)
                begin
                    mem[i] = $urandom_range(0, 255);
                    host.wr(ofs[i], 8'(mem[i]));
                end
                for (int i = 0; i < 6; i++)
                    rdx(i);
            end
        end
        for (int k = 0; k < 3; k++)
        begin
            t = $urandom_range(8, 30);
            mem[2*k] = t << 1;
            go(k, t, 0);
            mem[2*k] = (t - 5) << 1;
            go(k, t - 5, 0);
            t = $urandom_range(0, t - 6);
            mem[2*k] = (t << 1) | 1;
            go(k, t, 0);
            if (k < 2)
            begin
                s = $urandom_range(t + 1, 60);
                mem[2*k+1] = (s << 1) | 1;
                host.wr(ofs[2*k+1], 8'(mem[2*k+1]));
                go(k, s, 1);
                go(k, t, 1);
            end
        end
        host.wr(ofs[5], 8'($urandom_range(0, 255)));
        for (int i = 0; i < 6; i++)
            rdx(i);
        $display("test ramps done");
        tally_and_finish();
    end
endmodule : tb_buck_code_regs
